// >>> dv/tcr_timer_ctrl_bench.sv
// self-checking bench for the timer control block
// assumes the monitor is bound by its own file
`timescale 1ns/100ps
module tcr_timer_ctrl_bench;
    import tcr_pkg::*;
    typedef struct packed {
        logic [1:0] sel;
        logic xe;
        logic [3:0] np;
        logic [7:0] delta;
    } tcr_row_t;
    // counts over 64 mclk; ext rows count pin pulses only
    tcr_row_t rows [6] = '{'{2'b00, 1'b0, 4'h0, 8'h10}, '{2'b01, 1'b0, 4'h0, 8'h20},
        '{2'b10, 1'b0, 4'h0, 8'h08}, '{2'b11, 1'b1, 4'h5, 8'h05},
        '{2'b11, 1'b0, 4'h3, 8'h03}, '{2'b11, 1'b1, 4'h0, 8'h00}};
    logic mclk;
    logic sys_rst;
    logic cap_one;
    logic cap_two;
    logic ext_pin;
    logic timer_irq;
    logic [7:0] bus_rdata;
    logic [7:0] rd_val;
    logic [7:0] cnt_a;
    tcr_bus_req_t bus_req;
    tcr_pins_t pins;
    int bad_count = 0;
    int samples_checked = 0;
    tcr_timer_ctrl tcr_timer_ctrl_inst (.mclk(mclk), .sys_rst(sys_rst), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .capture_pin_one(cap_one), .capture_pin_two(cap_two),
        .ext_timer_clock_pin(ext_pin), .pins(pins), .timer_irq(timer_irq));
    // ****************************************
    // bus and compare tasks
    // ****************************************
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus_req.wr <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus_req.rd <= 1'b0;
        #1 d = bus_rdata;
    endtask : rd_reg
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // generous: the sequence needs well under 1000 cycles
    initial begin
        repeat (4000) @(posedge mclk);
        bad_count++;
        report_and_stop();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        bus_req = '0;
        cap_one = 1'b1;
        cap_two = 1'b1;
        ext_pin = 1'b0;
        sys_rst = 1'b1;
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        rd_reg(4'h1, rd_val);
        chk("ctrl two reset", 8'h00, rd_val);
        chk("pins after reset", 8'h00, {4'h0, pins});
        rd_reg(4'hF, rd_val);
        chk("unmapped read", 8'h00, rd_val);
        wr_reg(4'h1, 8'hC0);
        chk("pin enables", 8'h03, {6'h00, pins.cmp_one_oe, pins.cmp_two_oe});
        wr_reg(4'h0, 8'h1D);
        chk("forced high", 8'h03, {6'h00, pins.cmp_one_out, pins.cmp_two_out});
        wr_reg(4'h0, 8'h18);
        chk("forced low", 8'h00, {6'h00, pins.cmp_one_out, pins.cmp_two_out});
        wr_reg(4'h0, 8'h00);
        foreach (rows[i]) begin
            wr_reg(4'h1, {4'b1100, rows[i].sel, 1'b0, rows[i].xe});
            rd_reg(4'h8, cnt_a);
            for (int k = 0; k < 62; k++) begin
                @(posedge mclk);
                ext_pin <= (k < rows[i].np * 6) && (k % 6 < 3);
            end
            rd_reg(4'h8, rd_val);
            chk("count step", rows[i].delta, rd_val - cnt_a);
        end
        // counter now stopped, so only capture flags move
        wr_reg(4'h0, 8'h80);
        chk("irq idle", 8'h00, {7'h00, timer_irq});
        cap_one <= 1'b0;
        repeat (4) @(posedge mclk);
        rd_reg(4'h2, rd_val);
        chk("falling capture", 8'h80, rd_val & 8'h90);
        chk("capture irq", 8'h01, {7'h00, timer_irq});
        rd_reg(4'hA, rd_val);
        chk("irq after clear", 8'h00, {7'h00, timer_irq});
        wr_reg(4'h0, 8'h82);
        cap_one <= 1'b1;
        repeat (4) @(posedge mclk);
        rd_reg(4'h2, rd_val);
        chk("rising capture", 8'h80, rd_val & 8'h90);
        wr_reg(4'h0, 8'h02);
        chk("capture irq masked", 8'h00, {7'h00, timer_irq});
        rd_reg(4'h2, rd_val);
        rd_reg(4'hA, rd_val);
        wr_reg(4'h1, 8'hCE);
        cap_one <= 1'b0;
        cap_two <= 1'b0;
        repeat (4) @(posedge mclk);
        rd_reg(4'h2, rd_val);
        chk("wrong edges ignored", 8'h00, rd_val & 8'h90);
        cap_two <= 1'b1;
        repeat (4) @(posedge mclk);
        rd_reg(4'h2, rd_val);
        chk("rising capture two", 8'h10, rd_val & 8'h90);
        // compare matches: counter reset while it is stopped
        wr_reg(4'h3, 8'h00);
        wr_reg(4'h4, 8'h10);
        wr_reg(4'h5, 8'h00);
        wr_reg(4'h6, 8'h20);
        wr_reg(4'h0, 8'h05);
        wr_reg(4'h8, 8'h00);
        wr_reg(4'h1, 8'hC4);
        chk("pins before match", 8'h00, {6'h00, pins.cmp_one_out, pins.cmp_two_out});
        repeat (80) @(posedge mclk);
        chk("pins after match", 8'h03, {6'h00, pins.cmp_one_out, pins.cmp_two_out});
        wr_reg(4'h0, 8'h20);
        chk("overflow irq", 8'h01, {7'h00, timer_irq});
        wr_reg(4'h0, 8'h40);
        chk("compare irq", 8'h01, {7'h00, timer_irq});
        rd_reg(4'h2, rd_val);
        wr_reg(4'h4, 8'h10);
        rd_reg(4'h2, rd_val);
        wr_reg(4'h6, 8'h20);
        chk("compare irq cleared", 8'h00, {7'h00, timer_irq});
        // modulation with one pulse also set
        wr_reg(4'h0, 8'h04);
        wr_reg(4'h8, 8'h00);
        wr_reg(4'h1, 8'hB4);
        repeat (60) @(posedge mclk);
        chk("modulation low", 8'h00, {7'h00, pins.cmp_one_out});
        repeat (20) @(posedge mclk);
        chk("modulation high", 8'h01, {7'h00, pins.cmp_one_out});
        rd_reg(4'h2, rd_val);
        chk("period flag", 8'h80, rd_val & 8'h80);
        // one pulse from a falling capture edge
        cap_one <= 1'b1;
        wr_reg(4'h1, 8'hA4);
        cap_one <= 1'b0;
        repeat (10) @(posedge mclk);
        chk("pulse start", 8'h01, {7'h00, pins.cmp_one_out});
        repeat (50) @(posedge mclk);
        chk("pulse end", 8'h00, {7'h00, pins.cmp_one_out});
        report_and_stop();
    end
endmodule : tcr_timer_ctrl_bench

// >>> dv/tcr_timer_ctrl_monitor.sv
// port checker for the timer control block
// assumes bind onto tcr_timer_ctrl, single mclk domain
`timescale 1ns/100ps
module tcr_timer_ctrl_monitor #(
    parameter bit HAS_EXT_CLK = 1'b1
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire tcr_pkg::tcr_bus_req_t bus_req,
    input wire logic [7:0] bus_rdata,
    input wire logic capture_pin_one,
    input wire logic capture_pin_two,
    input wire logic ext_timer_clock_pin,
    input wire tcr_pkg::tcr_pins_t pins,
    input wire logic timer_irq
);
    import tcr_pkg::*;
    // ****************************************
    // shadow of both control registers
    // ****************************************
    logic [7:0] c1_r;
    logic [7:0] c2_r;
    logic wr0;
    logic wr1;
    assign wr0 = bus_req.wr && bus_req.addr == 4'h0;
    assign wr1 = bus_req.wr && bus_req.addr == 4'h1;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            c1_r <= 8'h00;
            c2_r <= 8'h00;
        end else begin
            if (wr0) c1_r <= bus_req.wdata;
            if (wr1) c2_r <= bus_req.wdata;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // flags seen set under their enables: cap1 cmp1 ovf cap2 cmp2
    sequence flag_read_s;
        bus_req.rd && bus_req.addr == 4'h2 ##1 |(bus_rdata & {c1_r[7:5], c1_r[7:6], 3'b000});
    endsequence
    // ****************************************
    // assertions
    // ****************************************
    oe_one_follow_a: assert property (wr1 |=> pins.cmp_one_oe == $past(bus_req.wdata[7]))
        else $error("pin one enable not taken from write");
    oe_two_follow_a: assert property (wr1 |=> pins.cmp_two_oe == $past(bus_req.wdata[6]))
        else $error("pin two enable not taken from write");
    force_one_level_a: assert property (c1_r[3] && c2_r[7] && c2_r[5:4] == 2'b00 |->
        pins.cmp_one_out == c1_r[0])
        else $error("forced level one missing");
    force_two_level_a: assert property (c1_r[4] && c2_r[6] |-> pins.cmp_two_out == c1_r[2])
        else $error("forced level two missing");
    irq_quiet_a: assert property (c1_r[7:5] == 3'b000 |-> !timer_irq)
        else $error("interrupt with all enables clear");
    irq_flag_seen_a: assert property (flag_read_s |-> timer_irq)
        else $error("enabled flag gave no interrupt");
    ctrl_two_read_a: assert property (bus_req.rd && bus_req.addr == 4'h1 |=>
        bus_rdata == $past(c2_r))
        else $error("second control readback wrong");
    ctrl_one_read_a: assert property (bus_req.rd && bus_req.addr == 4'h0 |=>
        bus_rdata == $past(c1_r))
        else $error("first control readback wrong");
    rdata_idle_a: assert property (!bus_req.rd |=> bus_rdata == 8'h00)
        else $error("read data outside read slot");
    unmapped_read_a: assert property (bus_req.rd && bus_req.addr > 4'hC |=> bus_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule : tcr_timer_ctrl_monitor

bind tcr_timer_ctrl tcr_timer_ctrl_monitor #(.HAS_EXT_CLK(HAS_EXT_CLK)) tcr_timer_ctrl_monitor_inst (
    .mclk(mclk), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .capture_pin_one(capture_pin_one), .capture_pin_two(capture_pin_two),
    .ext_timer_clock_pin(ext_timer_clock_pin), .pins(pins), .timer_irq(timer_irq));

// >>> hw/tcr_defs.svh
// constants for the timer control register block
// assumes inclusion by the design file only
`ifndef TCR_DEFS_SVH
`define TCR_DEFS_SVH

// register offsets on the plain register port
`define TCR_OFF_CTRL_ONE 4'h0
`define TCR_OFF_CTRL_TWO 4'h1
`define TCR_OFF_FLAGS 4'h2
`define TCR_OFF_CMP1_HI 4'h3
`define TCR_OFF_CMP1_LO 4'h4
`define TCR_OFF_CMP2_HI 4'h5
`define TCR_OFF_CMP2_LO 4'h6
`define TCR_OFF_CNT_HI 4'h7
`define TCR_OFF_CNT_LO 4'h8
`define TCR_OFF_CAP1_HI 4'h9
`define TCR_OFF_CAP1_LO 4'hA
`define TCR_OFF_CAP2_HI 4'hB
`define TCR_OFF_CAP2_LO 4'hC

// reset and reload values
`define TCR_CTRL_ONE_RST 8'h00
`define TCR_CTRL_TWO_RST 8'h00
`define TCR_CNT_RST 16'hFFFC
`define TCR_PWM_RELOAD 16'hFFFC

// clock select codes
`define TCR_CLK_DIV4 2'b00
`define TCR_CLK_DIV2 2'b01
`define TCR_CLK_DIV8 2'b10
`define TCR_CLK_EXT 2'b11

// flag register bit positions
`define TCR_FLAG_CAP1 7
`define TCR_FLAG_CMP1 6
`define TCR_FLAG_OVF 5
`define TCR_FLAG_CAP2 4
`define TCR_FLAG_CMP2 3

`endif

// >>> hw/tcr_pkg.sv
// types for the timer control register block
// assumes tcr_defs.svh is on the include path
package tcr_pkg;

    // first control register layout, msb first
    typedef struct packed {
        logic capture_irq_enable;
        logic compare_irq_enable;
        logic overflow_irq_enable;
        logic force_cmp_two;
        logic force_cmp_one;
        logic cmp_two_level;
        logic capture_one_edge;
        logic cmp_one_level;
    } tcr_ctrl_one_t;

    // second control register layout, msb first
    typedef struct packed {
        logic compare_pin_one_enable;
        logic compare_pin_two_enable;
        logic one_pulse_mode;
        logic pwm_mode;
        logic [1:0] clock_select;
        logic capture_two_edge;
        logic ext_clock_edge;
    } tcr_ctrl_two_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tcr_bus_req_t;

    typedef struct packed {
        logic cmp_one_out;
        logic cmp_one_oe;
        logic cmp_two_out;
        logic cmp_two_oe;
    } tcr_pins_t;

    typedef enum logic [1:0] {
        TCR_OP_IDLE,
        TCR_OP_WAIT,
        TCR_OP_PULSE
    } tcr_pulse_st_t;

    typedef struct packed {
        tcr_ctrl_one_t ctrl_one;
        tcr_ctrl_two_t ctrl_two;
        logic [7:0] rdata;
        logic [15:0] counter;
        logic [15:0] cmp_one;
        logic [15:0] cmp_two;
        logic [7:0] cmp_hi_hold;
        logic [1:0] cmp_inhibit;
        logic [15:0] cap_one;
        logic [15:0] cap_two;
        logic [7:0] flags;
        logic flags_read;
        logic [2:0] presc;
        logic [2:0] cap_one_d;
        logic [2:0] cap_two_d;
        logic [2:0] ext_d;
        logic cmp_one_pin;
        logic cmp_two_pin;
        tcr_pulse_st_t pulse_st;
    } tcr_state_t;

endpackage : tcr_pkg

// >>> hw/tcr_timer_ctrl.sv
// 16-bit timer with its two control registers and data registers
// assumes a synchronous plain register port and synchronous pin inputs
//
// Notes on behaviour
// R1 - capture enable passes either capture flag
// R2 - compare enable bit 6 passes compare flags
// R3 - overflow enable bit 5 passes overflow
// R4 - force two copies level two
// R5 - force one copies level one
// R6 - compare two match drives level two
// R7 - level two is second level on pin one
// R8 - compare one match drives level one
// R9 - capture one edge: 0 falling, 1 rising
// R10 - capture two edge bit 1 selects edge
// R11 - pin one enable only routes pin
// R12 - pin two enable only routes pin
// R13 - one pulse started by capture one edge
// R14 - modulation: value one pulse, value two period
// R15 - clock select 00 div4 01 div2 10 div8
// R16 - missing external pin stops the counter
// R17 - external edge bit: 0 falling, 1 rising
// R18 - modulation wins over one pulse
// R19 - interrupt is or of enabled flags
// R20 - second control register resets to zero
`timescale 1ns/100ps
`include "tcr_defs.svh"

module tcr_timer_ctrl #(
    parameter bit HAS_EXT_CLK = 1'b1
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire tcr_pkg::tcr_bus_req_t bus_req,
    output logic [7:0] bus_rdata,
    input wire logic capture_pin_one,
    input wire logic capture_pin_two,
    input wire logic ext_timer_clock_pin,
    output tcr_pkg::tcr_pins_t pins,
    output logic timer_irq
);
    import tcr_pkg::*;

    initial begin
        if (HAS_EXT_CLK !== 1'b0 && HAS_EXT_CLK !== 1'b1) begin
            $error("HAS_EXT_CLK must be 0 or 1");
        end
    end

    tcr_state_t st_r;
    tcr_state_t st_nxt;

    // ****************************************
    // edge and tick helpers
    // ****************************************
    logic cap_one_rise, cap_one_fall, cap_two_rise, cap_two_fall;
    logic ext_rise, ext_fall, tick, cap_one_ev, cap_two_ev;
    logic match_one, match_two, pwm_on, opm_on;

    always_comb begin
        // delayed copies only; pins are already synchronous
        cap_one_rise = st_r.cap_one_d[1] & ~st_r.cap_one_d[2];
        cap_one_fall = ~st_r.cap_one_d[1] & st_r.cap_one_d[2];
        cap_two_rise = st_r.cap_two_d[1] & ~st_r.cap_two_d[2];
        cap_two_fall = ~st_r.cap_two_d[1] & st_r.cap_two_d[2];
        ext_rise = st_r.ext_d[1] & ~st_r.ext_d[2];
        ext_fall = ~st_r.ext_d[1] & st_r.ext_d[2];
        cap_one_ev = st_r.ctrl_one.capture_one_edge ? cap_one_rise : cap_one_fall; // R9
        cap_two_ev = st_r.ctrl_two.capture_two_edge ? cap_two_rise : cap_two_fall; // R10
        pwm_on = st_r.ctrl_two.pwm_mode;
        opm_on = st_r.ctrl_two.one_pulse_mode & ~pwm_on; // R18
        case (st_r.ctrl_two.clock_select) // R15
            `TCR_CLK_DIV4: tick = (st_r.presc[1:0] == 2'b11);
            `TCR_CLK_DIV2: tick = st_r.presc[0];
            `TCR_CLK_DIV8: tick = (st_r.presc == 3'b111);
            // no pin means no edges: counter holds
            default: begin
                tick = HAS_EXT_CLK
                       & (st_r.ctrl_two.ext_clock_edge ? ext_rise : ext_fall); // R16 R17
            end
        endcase
        match_one = tick & ~st_r.cmp_inhibit[0] & (st_r.counter == st_r.cmp_one);
        match_two = tick & ~st_r.cmp_inhibit[1] & (st_r.counter == st_r.cmp_two);
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic [15:0] cnt_inc;
        cnt_inc = 16'h0000;
        st_nxt = st_r;
        st_nxt.rdata = 8'h00;
        st_nxt.cap_one_d = {st_r.cap_one_d[1:0], capture_pin_one};
        st_nxt.cap_two_d = {st_r.cap_two_d[1:0], capture_pin_two};
        st_nxt.ext_d = {st_r.ext_d[1:0], ext_timer_clock_pin};
        st_nxt.presc = st_r.presc + 3'b001;
        cnt_inc = st_r.counter + 16'h0001;

        // counter and events
        if (tick) begin
            st_nxt.counter = cnt_inc;
            if (st_r.counter == 16'hFFFF) begin
                st_nxt.flags[`TCR_FLAG_OVF] = 1'b1;
            end
        end
        if (match_one) begin
            if (!pwm_on) begin
                st_nxt.flags[`TCR_FLAG_CMP1] = 1'b1;
            end
            // compare logic keeps running whatever the pin enable
            if (!pwm_on && !opm_on) begin
                st_nxt.cmp_one_pin = st_r.ctrl_one.cmp_one_level; // R8 R11
            end
        end
        if (match_two) begin
            if (pwm_on) begin
                // period end doubles as capture one event
                st_nxt.flags[`TCR_FLAG_CAP1] = 1'b1;
                st_nxt.counter = `TCR_PWM_RELOAD; // R14
                st_nxt.cmp_one_pin = st_r.ctrl_one.cmp_two_level; // R7
            end else begin
                st_nxt.flags[`TCR_FLAG_CMP2] = 1'b1;
                st_nxt.cmp_two_pin = st_r.ctrl_one.cmp_two_level; // R6 R12
            end
        end
        if (pwm_on && match_one) begin
            st_nxt.cmp_one_pin = st_r.ctrl_one.cmp_one_level; // R14
        end

        // capture one: disconnected in modulation mode
        if (cap_one_ev && !pwm_on) begin
            st_nxt.flags[`TCR_FLAG_CAP1] = 1'b1;
            st_nxt.cap_one = st_r.counter;
        end
        if (cap_two_ev) begin
            st_nxt.flags[`TCR_FLAG_CAP2] = 1'b1;
            st_nxt.cap_two = st_r.counter;
        end

        // one pulse sequencing
        case (st_r.pulse_st)
            TCR_OP_IDLE: begin
                if (opm_on && cap_one_ev) begin
                    st_nxt.counter = `TCR_PWM_RELOAD; // R13
                    st_nxt.cmp_one_pin = st_r.ctrl_one.cmp_two_level; // R7
                    st_nxt.pulse_st = TCR_OP_PULSE;
                end
            end
            TCR_OP_PULSE: begin
                if (!opm_on) begin
                    st_nxt.pulse_st = TCR_OP_IDLE;
                end else if (match_one) begin
                    st_nxt.cmp_one_pin = st_r.ctrl_one.cmp_one_level; // R13
                    st_nxt.pulse_st = TCR_OP_IDLE;
                end
            end
            default: st_nxt.pulse_st = TCR_OP_IDLE;
        endcase

        // register port: flag clear needs a prior flag read
        if (bus_req.rd) begin
            case (bus_req.addr)
                `TCR_OFF_CTRL_ONE: st_nxt.rdata = st_r.ctrl_one;
                `TCR_OFF_CTRL_TWO: st_nxt.rdata = st_r.ctrl_two;
                `TCR_OFF_FLAGS: st_nxt.rdata = st_r.flags;
                `TCR_OFF_CMP1_HI: st_nxt.rdata = st_r.cmp_one[15:8];
                `TCR_OFF_CMP1_LO: st_nxt.rdata = st_r.cmp_one[7:0];
                `TCR_OFF_CMP2_HI: st_nxt.rdata = st_r.cmp_two[15:8];
                `TCR_OFF_CMP2_LO: st_nxt.rdata = st_r.cmp_two[7:0];
                `TCR_OFF_CNT_HI: st_nxt.rdata = st_r.counter[15:8];
                `TCR_OFF_CNT_LO: st_nxt.rdata = st_r.counter[7:0];
                `TCR_OFF_CAP1_HI: st_nxt.rdata = st_r.cap_one[15:8];
                `TCR_OFF_CAP1_LO: st_nxt.rdata = st_r.cap_one[7:0];
                `TCR_OFF_CAP2_HI: st_nxt.rdata = st_r.cap_two[15:8];
                `TCR_OFF_CAP2_LO: st_nxt.rdata = st_r.cap_two[7:0];
                default: st_nxt.rdata = 8'h00;
            endcase
        end
        if (bus_req.wr) begin
            case (bus_req.addr)
                `TCR_OFF_CTRL_ONE: st_nxt.ctrl_one = bus_req.wdata;
                `TCR_OFF_CTRL_TWO: st_nxt.ctrl_two = bus_req.wdata;
                `TCR_OFF_CMP1_HI: begin
                    st_nxt.cmp_hi_hold = bus_req.wdata;
                    st_nxt.cmp_inhibit[0] = 1'b1;
                end
                `TCR_OFF_CMP1_LO: begin
                    st_nxt.cmp_one = {st_r.cmp_hi_hold, bus_req.wdata};
                    st_nxt.cmp_inhibit[0] = 1'b0;
                end
                `TCR_OFF_CMP2_HI: begin
                    st_nxt.cmp_hi_hold = bus_req.wdata;
                    st_nxt.cmp_inhibit[1] = 1'b1;
                end
                `TCR_OFF_CMP2_LO: begin
                    st_nxt.cmp_two = {st_r.cmp_hi_hold, bus_req.wdata};
                    st_nxt.cmp_inhibit[1] = 1'b0;
                end
                `TCR_OFF_CNT_LO: st_nxt.counter = `TCR_CNT_RST;
                default: ;
            endcase
        end
        if (bus_req.rd || bus_req.wr) begin
            st_nxt.flags_read = (bus_req.rd && bus_req.addr == `TCR_OFF_FLAGS);
            // a clear in the same cycle as a new event loses to the event
            if (st_r.flags_read) begin
                case (bus_req.addr)
                    `TCR_OFF_CAP1_LO: begin
                        st_nxt.flags[`TCR_FLAG_CAP1] = (cap_one_ev & ~pwm_on)
                                                       | (pwm_on & match_two);
                    end
                    `TCR_OFF_CMP1_LO: st_nxt.flags[`TCR_FLAG_CMP1] = match_one & ~pwm_on;
                    `TCR_OFF_CNT_LO: st_nxt.flags[`TCR_FLAG_OVF] = tick & (st_r.counter == 16'hFFFF);
                    `TCR_OFF_CAP2_LO: st_nxt.flags[`TCR_FLAG_CAP2] = cap_two_ev;
                    `TCR_OFF_CMP2_LO: st_nxt.flags[`TCR_FLAG_CMP2] = match_two & ~pwm_on;
                    default: ;
                endcase
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    always_comb begin
        // forcing is a level, held while the bit stays set
        pins.cmp_one_out = st_r.ctrl_one.force_cmp_one ? st_r.ctrl_one.cmp_one_level
                                                       : st_r.cmp_one_pin; // R5
        pins.cmp_two_out = st_r.ctrl_one.force_cmp_two ? st_r.ctrl_one.cmp_two_level
                                                       : st_r.cmp_two_pin; // R4
        pins.cmp_one_oe = st_r.ctrl_two.compare_pin_one_enable; // R11
        pins.cmp_two_oe = st_r.ctrl_two.compare_pin_two_enable; // R12
        bus_rdata = st_r.rdata;
        timer_irq = (st_r.ctrl_one.capture_irq_enable
                     & (st_r.flags[`TCR_FLAG_CAP1] | st_r.flags[`TCR_FLAG_CAP2])) // R1
                  | (st_r.ctrl_one.compare_irq_enable
                     & (st_r.flags[`TCR_FLAG_CMP1] | st_r.flags[`TCR_FLAG_CMP2])) // R2
                  | (st_r.ctrl_one.overflow_irq_enable & st_r.flags[`TCR_FLAG_OVF]); // R3 R19
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
            st_r.ctrl_one <= `TCR_CTRL_ONE_RST;
            st_r.ctrl_two <= `TCR_CTRL_TWO_RST; // R20
            st_r.counter <= `TCR_CNT_RST;
            st_r.cmp_one <= 16'hFFFF;
            st_r.cmp_two <= 16'hFFFF;
            st_r.cap_one_d <= 3'b111;
            st_r.cap_two_d <= 3'b111;
            st_r.ext_d <= 3'b111;
            st_r.pulse_st <= TCR_OP_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule : tcr_timer_ctrl
